// ---- design/hic_host_control.sv ----
`timescale 1ns/10ps
// What this block does
// - Host control word holds nine programmable bits and the halt acknowledge at fixed positions.
// - Host and internal processor both read and write the control word.
// - Halt acknowledge sets once the processor has really halted.
// - Halt acknowledge clears when the halt bit is cleared.
// - Last-byte code names the last byte: 00 byte3 ... 11 byte0.
// - With prefetch on, fetch next word after last byte; type chosen by bit.
// - 8-bit host: both code bits select the triggering byte access.
// - 16-bit host: upper code bit alone selects the triggering word.
// - 32-bit host: every access of the chosen type triggers prefetch.
// - Writing 1 to soft reset resets the core and control word; mailboxes keep their values.
// - Refresh requests continue during internal reset with the pin high.
// - Chip select sampled just before pin reset release sets boot mode.
// - Soft reset reuses the boot mode of the last pin reset.
// - Soft reset bit is never stored; it always reads back as zero.
// - Two plain 16-bit mailbox words hold values for host and processor.
// - Bit 8 is the host-to-processor nonmaskable interrupt request.
// - Request is raised regardless of masks but held off while halt is set, cleared when taken.
// - Halt bit stops the processor; refresh and video keep running.
// - Halt comes up set if chip select was high at reset release.
// - Increment bit enables prefetch; prefetch-after-write picks read or write.
module hic_host_control (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_host_chip_select_pin,
    input wire hic_pkg::hic_reg_req_t i_host_req,
    input wire hic_pkg::hic_reg_req_t i_cpu_req,
    input wire hic_pkg::hic_host_acc_t i_host_acc,
    input wire logic [1:0] i_host_width,
    input wire logic i_cpu_halted,
    input wire logic i_nmi_taken,
    output logic [15:0] o_host_rdata,
    output logic [15:0] o_cpu_rdata,
    output logic o_core_reset,
    output logic o_refresh_req,
    output logic o_halt,
    output logic o_nmi_req,
    output logic o_nmi_mode,
    output logic o_cache_flush,
    output logic o_prefetch,
    output logic o_self_boot
);
    import hic_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset synchroniser and chip-select synchroniser
    logic rst_s1_r;
    logic rst_s2_r;
    logic cs_s1_r;
    logic cs_s2_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    always_ff @(posedge i_clk) begin
        cs_s1_r <= i_host_chip_select_pin;
        cs_s2_r <= cs_s1_r;
    end

    wire pin_rst_n = rst_s2_r;

    ////////////////////////////////////////////////////////////////////
    // Boot mode capture, tracked throughout pin reset
    logic boot_halt_r;
    logic pin_rst_d_r;
    wire pin_release = pin_rst_n & ~pin_rst_d_r;

    always_ff @(posedge i_clk) begin
        pin_rst_d_r <= pin_rst_n;
        if (!pin_rst_n) begin
            boot_halt_r <= cs_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Soft reset sequencer
    logic [3:0] srst_cnt_r;
    logic [3:0] srst_cnt_nxt;
    logic srst_start;
    wire srst_active = (srst_cnt_r != 4'h0);

    assign srst_cnt_nxt = srst_start ? HIC_SRST_CYCLES :
                          (srst_active ? srst_cnt_r - 4'h1 : 4'h0);

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            srst_cnt_r <= 4'h0;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    wire core_rst = ~pin_rst_n | srst_active;
    assign o_core_reset = core_rst;

    ////////////////////////////////////////////////////////////////////
    // Refresh ticks during internal reset while the pin is released
    logic [10:0] ref_cnt_r;
    logic ref_pulse_r;
    wire ref_wrap = (ref_cnt_r == 11'(HIC_REFRESH_CYC - 1));

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            ref_cnt_r <= 11'h000;
            ref_pulse_r <= 1'b0;
        end else begin
            ref_cnt_r <= (srst_active && !ref_wrap) ? ref_cnt_r + 11'h001 : 11'h000;
            ref_pulse_r <= srst_active & (ref_cnt_r == 11'h000);
        end
    end
    assign o_refresh_req = ref_pulse_r;

    ////////////////////////////////////////////////////////////////////
    // Register decode and write selection
    wire host_ctl_wr = i_host_req.wr && (i_host_req.addr == HIC_ADDR_CONTROL_HIGH);
    wire cpu_ctl_wr = i_cpu_req.wr && (i_cpu_req.addr == HIC_ADDR_CONTROL_HIGH);
    wire host_lo_wr = i_host_req.wr && (i_host_req.addr == HIC_ADDR_MAILBOX_LOW);
    wire cpu_lo_wr = i_cpu_req.wr && (i_cpu_req.addr == HIC_ADDR_MAILBOX_LOW);
    wire host_hi_wr = i_host_req.wr && (i_host_req.addr == HIC_ADDR_MAILBOX_HIGH);
    wire cpu_hi_wr = i_cpu_req.wr && (i_cpu_req.addr == HIC_ADDR_MAILBOX_HIGH);
    wire ctl_wr = host_ctl_wr | cpu_ctl_wr;
    wire [15:0] ctl_wdata = host_ctl_wr ? i_host_req.wdata : i_cpu_req.wdata;
    assign srst_start = ctl_wr & ctl_wdata[HIC_BIT_SOFT_RESET] & ~srst_active & ~pin_release;

    ////////////////////////////////////////////////////////////////////
    // Control word and mailboxes
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic [15:0] mbox_lo_r;
    logic [15:0] mbox_hi_r;
    logic halt_acknowledge_bit_r;

    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_wr) begin
            ctl_nxt = ctl_wdata & HIC_CTL_WMASK;
        end
        if (i_nmi_taken && !(ctl_wr && ctl_wdata[HIC_BIT_NMI_REQ])) begin
            ctl_nxt[HIC_BIT_NMI_REQ] = 1'b0;
        end
        ctl_nxt[HIC_BIT_SOFT_RESET] = 1'b0;
    end

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            ctl_r <= HIC_CTL_RESET;
            mbox_lo_r <= HIC_MBOX_RESET;
            mbox_hi_r <= HIC_MBOX_RESET;
            halt_acknowledge_bit_r <= 1'b0;
        end else if (pin_release || srst_active) begin
            ctl_r <= HIC_CTL_RESET;
            ctl_r[HIC_BIT_HALT] <= boot_halt_r;
            halt_acknowledge_bit_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            if (host_lo_wr || cpu_lo_wr) begin
                mbox_lo_r <= host_lo_wr ? i_host_req.wdata : i_cpu_req.wdata;
            end
            if (host_hi_wr || cpu_hi_wr) begin
                mbox_hi_r <= host_hi_wr ? i_host_req.wdata : i_cpu_req.wdata;
            end
            halt_acknowledge_bit_r <= ctl_r[HIC_BIT_HALT] & i_cpu_halted;
        end
    end

    wire [15:0] ctl_view = ctl_r | (16'(halt_acknowledge_bit_r) << HIC_BIT_HALT_ACK);

    function automatic logic [15:0] hic_read(input logic [31:0] a, input logic [15:0] c,
                                             input logic [15:0] lo, input logic [15:0] hi);
        hic_read = (a == HIC_ADDR_CONTROL_HIGH) ? c :
                   (a == HIC_ADDR_MAILBOX_LOW) ? lo :
                   (a == HIC_ADDR_MAILBOX_HIGH) ? hi : 16'h0000;
    endfunction

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            o_host_rdata <= 16'h0000;
            o_cpu_rdata <= 16'h0000;
        end else begin
            o_host_rdata <= hic_read(i_host_req.addr, ctl_view, mbox_lo_r, mbox_hi_r);
            o_cpu_rdata <= hic_read(i_cpu_req.addr, ctl_view, mbox_lo_r, mbox_hi_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Processor controls
    assign o_halt = ctl_r[HIC_BIT_HALT];
    assign o_nmi_req = ctl_r[HIC_BIT_NMI_REQ] & ~ctl_r[HIC_BIT_HALT];
    assign o_nmi_mode = ctl_r[HIC_BIT_NMI_MODE];
    assign o_cache_flush = ctl_r[HIC_BIT_CACHE_FLUSH];
    assign o_self_boot = ~boot_halt_r;

    ////////////////////////////////////////////////////////////////////
    // Prefetch trigger
    wire [1:0] lb_code = {ctl_r[HIC_BIT_LB_HIGH], ctl_r[HIC_BIT_LB_LOW]};
    wire [1:0] last_byte = 2'h3 - lb_code;
    wire type_ok = (i_host_acc.is_write == ctl_r[HIC_BIT_PF_WRITE]);
    wire pos8 = (i_host_acc.byte_sel == last_byte);
    wire pos16 = (i_host_acc.byte_sel[1] == last_byte[1]);
    wire pos_ok = (i_host_width == HIC_HOST_32) ? 1'b1 :
                  (i_host_width == HIC_HOST_16) ? pos16 : pos8;
    wire pf_hit = i_host_acc.access & ctl_r[HIC_BIT_AUTO_INC] & type_ok & pos_ok;

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            o_prefetch <= 1'b0;
        end else begin
            o_prefetch <= pf_hit & ~core_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Soft reset window length, counted for the checks
    logic [4:0] srst_len_r;

    always_ff @(posedge i_clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            srst_len_r <= 5'h00;
        end else if (srst_active) begin
            srst_len_r <= srst_len_r + 5'h01;
        end else begin
            srst_len_r <= 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    halt_ack_set_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (o_halt && i_cpu_halted && !srst_active && !pin_release && !srst_start) |=>
        ctl_view[HIC_BIT_HALT_ACK] || srst_active)
        else $error("halt ack not set");
    halt_ack_clr_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        !o_halt |=> !halt_acknowledge_bit_r)
        else $error("halt ack stuck");
    srst_len_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        $rose(srst_active) |-> o_core_reset [*8])
        else $error("soft reset too short");
    srst_clear_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        srst_start |=> !ctl_r[HIC_BIT_SOFT_RESET])
        else $error("soft reset bit not cleared");
    host_wins_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (host_ctl_wr && cpu_ctl_wr && !srst_active && !pin_release && !srst_start) |=>
        ctl_r == ($past(i_host_req.wdata) & HIC_CTL_WMASK) ||
        (ctl_r == (($past(i_host_req.wdata) & HIC_CTL_WMASK) & 16'hFEFF)))
        else $error("host write lost");
    rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (ctl_view & 16'h240F) == 16'h0000)
        else $error("reserved bit set");
    nmi_clear_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_nmi_taken && !ctl_wr && !srst_active) |=> !ctl_r[HIC_BIT_NMI_REQ])
        else $error("nmi not cleared");
    pf_32_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_width == HIC_HOST_32 && i_host_acc.access && type_ok &&
         ctl_r[HIC_BIT_AUTO_INC] && !core_rst) |=> o_prefetch)
        else $error("prefetch missed");
    mbox_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (host_lo_wr && !srst_active && !pin_release) |=> mbox_lo_r == $past(i_host_req.wdata))
        else $error("mailbox write lost");
    boot_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        pin_release |=> o_halt == $past(boot_halt_r))
        else $error("boot halt wrong");

    lb_code_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_width == HIC_HOST_8 && i_host_acc.access && type_ok && !core_rst &&
         ctl_r[HIC_BIT_AUTO_INC] && lb_code == 2'h0 &&
         i_host_acc.byte_sel == 2'h3) |=> o_prefetch)
        else $error("last byte code misread");
    lb_byte8_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_width == HIC_HOST_8 && i_host_acc.access &&
         i_host_acc.byte_sel != 2'h3 - lb_code) |=> !o_prefetch)
        else $error("byte prefetch misplaced");
    lb_word16_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_width == HIC_HOST_16 && i_host_acc.access && type_ok && !core_rst &&
         ctl_r[HIC_BIT_AUTO_INC] && i_host_acc.byte_sel[1] != lb_code[1]) |=> o_prefetch)
        else $error("word prefetch missed");
    pf_type_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_acc.is_write != ctl_r[HIC_BIT_PF_WRITE]) |=> !o_prefetch)
        else $error("prefetch on wrong access type");
    pf_off_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        !ctl_r[HIC_BIT_AUTO_INC] |=> !o_prefetch)
        else $error("prefetch while disabled");
    pf_reset_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        core_rst |=> !o_prefetch)
        else $error("prefetch during reset");

    refresh_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        $rose(srst_active) |=> o_refresh_req)
        else $error("no refresh in soft reset");
    refresh_idle_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        !srst_active |=> !o_refresh_req)
        else $error("refresh outside soft reset");
    srst_count_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        $fell(srst_active) |-> srst_len_r == {1'b0, HIC_SRST_CYCLES})
        else $error("soft reset length wrong");
    soft_boot_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        $fell(srst_active) |-> o_halt == boot_halt_r)
        else $error("soft reset boot mode wrong");
    srst_reload_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        srst_active |=> (ctl_r & 16'h7FFF) == HIC_CTL_RESET)
        else $error("control not reloaded");

    nmi_halt_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        o_halt |-> !o_nmi_req)
        else $error("interrupt while halted");
    nmi_flag_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        o_nmi_req |-> ctl_r[HIC_BIT_NMI_REQ])
        else $error("interrupt without request bit");
    cpu_mbox_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (cpu_hi_wr && !host_hi_wr && !srst_active && !pin_release) |=>
        mbox_hi_r == $past(i_cpu_req.wdata))
        else $error("processor mailbox write lost");
    host_mbox_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (host_hi_wr && !srst_active && !pin_release) |=> mbox_hi_r == $past(i_host_req.wdata))
        else $error("host mailbox write lost");
    host_read_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_host_req.addr == HIC_ADDR_CONTROL_HIGH) |=> o_host_rdata == $past(ctl_view))
        else $error("control read wrong");
    unmapped_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        (i_cpu_req.addr != HIC_ADDR_CONTROL_HIGH && i_cpu_req.addr != HIC_ADDR_MAILBOX_LOW &&
         i_cpu_req.addr != HIC_ADDR_MAILBOX_HIGH) |=> o_cpu_rdata == 16'h0000)
        else $error("unmapped read not zero");
    halt_acknowledge_bit_pin_a: assert property (@(posedge i_clk) disable iff (!pin_rst_n)
        pin_release |=> !halt_acknowledge_bit_r)
        else $error("halt ack after reset");

    srst_c: cover property (@(posedge i_clk) disable iff (!pin_rst_n) srst_start);
    pf_c: cover property (@(posedge i_clk) disable iff (!pin_rst_n) o_prefetch);
    halt_acknowledge_bit_c: cover property (@(posedge i_clk) disable iff (!pin_rst_n) $rose(halt_acknowledge_bit_r));
    ref_c: cover property (@(posedge i_clk) disable iff (!pin_rst_n) o_refresh_req);
    nmi_c: cover property (@(posedge i_clk) disable iff (!pin_rst_n) $fell(o_nmi_req));

endmodule

// ---- include/hic_pkg.sv ----
package hic_pkg;

    // Register byte addresses
    localparam logic [31:0] HIC_ADDR_MAILBOX_LOW = 32'hC00000D0;
    localparam logic [31:0] HIC_ADDR_MAILBOX_HIGH = 32'hC00000E0;
    localparam logic [31:0] HIC_ADDR_CONTROL_HIGH = 32'hC0000100;

    // Control field positions
    localparam int HIC_BIT_HALT_ACK = 4;
    localparam int HIC_BIT_LB_LOW = 5;
    localparam int HIC_BIT_LB_HIGH = 6;
    localparam int HIC_BIT_SOFT_RESET = 7;
    localparam int HIC_BIT_NMI_REQ = 8;
    localparam int HIC_BIT_NMI_MODE = 9;
    localparam int HIC_BIT_PF_WRITE = 11;
    localparam int HIC_BIT_AUTO_INC = 12;
    localparam int HIC_BIT_CACHE_FLUSH = 14;
    localparam int HIC_BIT_HALT = 15;

    // Writable bits: 4..9, 11, 12, 14, 15 minus the hardware-owned acknowledge
    localparam logic [15:0] HIC_CTL_WMASK = 16'hDBE0;
    localparam logic [15:0] HIC_CTL_RESET = 16'h0000;
    localparam logic [15:0] HIC_MBOX_RESET = 16'h0000;

    // Soft reset pulse length in clocks, refresh interval while in reset
    localparam logic [3:0] HIC_SRST_CYCLES = 4'h8;
    localparam int HIC_REFRESH_NS = 15600;
    localparam int HIC_CLK_NS = 10;
    localparam int HIC_REFRESH_CYC = HIC_REFRESH_NS / HIC_CLK_NS;

    // Host data width encodings
    localparam logic [1:0] HIC_HOST_8 = 2'h0;
    localparam logic [1:0] HIC_HOST_16 = 2'h1;
    localparam logic [1:0] HIC_HOST_32 = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [15:0] wdata;
    } hic_reg_req_t;

    typedef struct packed {
        logic access;
        logic is_write;
        logic [1:0] byte_sel;
    } hic_host_acc_t;

endpackage

// ---- testbench/hic_core_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Internal processor stand-in: halts and takes the interrupt, promptly or slowly
module hic_core_model (
    input wire logic i_clk,
    input wire logic i_halt,
    input wire logic i_nmi_req,
    input wire logic i_slow,
    output logic o_halted,
    output logic o_nmi_taken
);
    int hcnt = 0;
    int ncnt = 0;
    initial o_halted = 1'b0;
    initial o_nmi_taken = 1'b0;
    always @(posedge i_clk) begin
        hcnt <= i_halt ? hcnt + 1 : 0;
        o_halted <= i_halt && (hcnt >= (i_slow ? 5 : 0));
        ncnt <= (i_nmi_req && !o_nmi_taken) ? ncnt + 1 : 0;
        o_nmi_taken <= i_nmi_req && !o_nmi_taken && (ncnt >= (i_slow ? 4 : 0));
    end
endmodule

// ---- testbench/test_host_interface_control.sv ----
`timescale 1ns/10ps
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin err_total++; \
    $display("wrong value at %0t: got %h want %h", $time, x, y); end end
////////////////////////////////////////////////////////////////////////////////
module test_host_interface_control;
    import hic_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cs = 1'b0;
    logic slow = 1'b0;
    logic [1:0] width = HIC_HOST_8;
    hic_reg_req_t hreq = '0;
    hic_reg_req_t creq = '0;
    hic_host_acc_t acc = '0;
    logic halted, taken, core_rst, refr, halt, nmi, nonmaskable_context_mode, flush, pf, sboot;
    logic [15:0] hrd, crd, q, v, a, b, lfsr;
    logic [15:0] mbox_m [2];
    logic [1:0] lb;
    logic hit;
    int err_total = 0;
    int comparisons = 0;
    int i, k, c, n, s;
    hic_host_control dut (.i_clk(clk), .i_resetn(resetn), .i_host_chip_select_pin(cs),
        .i_host_req(hreq), .i_cpu_req(creq), .i_host_acc(acc), .i_host_width(width),
        .i_cpu_halted(halted), .i_nmi_taken(taken), .o_host_rdata(hrd), .o_cpu_rdata(crd),
        .o_core_reset(core_rst), .o_refresh_req(refr), .o_halt(halt), .o_nmi_req(nmi),
        .o_nmi_mode(nonmaskable_context_mode), .o_cache_flush(flush), .o_prefetch(pf), .o_self_boot(sboot));
    hic_core_model core (.i_clk(clk), .i_halt(halt), .i_nmi_req(nmi), .i_slow(slow),
        .o_halted(halted), .o_nmi_taken(taken));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic wr(input bit host, input logic [31:0] ad, input logic [15:0] d);
        @(posedge clk);
        if (host) hreq <= '{1'b1, 1'b0, ad, d};
        else creq <= '{1'b1, 1'b0, ad, d};
        if (ad == HIC_ADDR_MAILBOX_LOW) mbox_m[0] = d;
        if (ad == HIC_ADDR_MAILBOX_HIGH) mbox_m[1] = d;
        @(posedge clk);
        hreq <= '0;
        creq <= '0;
    endtask
    task automatic rd(input bit host, input logic [31:0] ad, output logic [15:0] r);
        @(posedge clk);
        if (host) hreq <= '{1'b0, 1'b1, ad, 16'h0000};
        else creq <= '{1'b0, 1'b1, ad, 16'h0000};
        @(posedge clk);
        hreq <= '0;
        creq <= '0;
        #1 r = host ? hrd : crd;
    endtask
    task automatic pin_reset(input logic sel);
        @(posedge clk);
        cs <= sel;
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task complete_run;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_total++;
        complete_run;
    end
    initial begin
        lfsr = 16'h003B;
        pin_reset(1'b0);
        `CHK(sboot, 1'b1)
        rd(1, HIC_ADDR_CONTROL_HIGH, q);
        `CHK(q, 16'h0000)
        for (i = 0; i < 4; i++) begin
            v = rnd();
            wr(i[0], i[1] ? HIC_ADDR_MAILBOX_HIGH : HIC_ADDR_MAILBOX_LOW, v);
            rd(!i[0], i[1] ? HIC_ADDR_MAILBOX_HIGH : HIC_ADDR_MAILBOX_LOW, q);
            `CHK(q, mbox_m[i[1]])
        end
        rd(0, 32'hC0000110, q);
        `CHK(q, 16'h0000)
        wr(1, HIC_ADDR_CONTROL_HIGH, 16'h5870);
        rd(0, HIC_ADDR_CONTROL_HIGH, q);
        `CHK(q, 16'h5860)
        `CHK(flush, 1'b1)
        for (s = 0; s < 2; s++) begin
            slow <= s[0];
            wr(0, HIC_ADDR_CONTROL_HIGH, 16'h8000);
            n = 0;
            do begin rd(1, HIC_ADDR_CONTROL_HIGH, q); n++; end while (q[4] !== 1'b1 && n < 12);
            `CHK(q, 16'h8010)
            wr(1, HIC_ADDR_CONTROL_HIGH, 16'h0000);
            rd(1, HIC_ADDR_CONTROL_HIGH, q);
            `CHK(q, 16'h0000)
            wr(1, HIC_ADDR_CONTROL_HIGH, 16'h0300);
            #1 `CHK({nmi, nonmaskable_context_mode}, 2'b11)
            n = 0;
            do begin rd(0, HIC_ADDR_CONTROL_HIGH, q); n++; end while (q[8] !== 1'b0 && n < 12);
            `CHK(q, 16'h0200)
        end
        for (i = 0; i < 4; i++) begin
            a = rnd() & 16'h5A60;
            b = rnd() & 16'h5A60;
            @(posedge clk);
            hreq <= '{1'b1, 1'b0, HIC_ADDR_CONTROL_HIGH, a};
            creq <= '{1'b1, 1'b0, HIC_ADDR_CONTROL_HIGH, b};
            @(posedge clk);
            hreq <= '0;
            creq <= '0;
            rd(0, HIC_ADDR_CONTROL_HIGH, q);
            `CHK(q, a)
        end
        for (c = 0; c < 16; c++) begin
            wr(1, HIC_ADDR_CONTROL_HIGH, {3'b000, c[3:2], 4'h0, c[1:0], 5'h00});
            lb = 2'h3 - c[1:0];
            for (k = 0; k < 24; k++) begin
                @(posedge clk);
                width <= k[4:3];
                acc <= '{1'b1, k[2], k[1:0]};
                @(posedge clk);
                acc <= '0;
                hit = (k[4:3] == 2) || (k[4:3] == 1 ? k[1] == lb[1] : k[1:0] == lb);
                #1 `CHK(pf, c[3] && (k[2] == c[2]) && hit)
            end
        end
        for (s = 0; s < 2; s++) begin
            if (s == 1) begin
                pin_reset(1'b1);
                `CHK(sboot, 1'b0)
            end
            @(posedge clk);
            cs <= !s[0];
            v = rnd();
            wr(1, HIC_ADDR_MAILBOX_LOW, v);
            wr(1, HIC_ADDR_CONTROL_HIGH, 16'h0080);
            @(posedge clk);
            #1 `CHK(core_rst, 1'b1)
            `CHK(refr, 1'b1)
            n = 0;
            while (core_rst !== 1'b0 && n < 20) begin @(posedge clk); #1 n++; end
            repeat (2) @(posedge clk);
            rd(1, HIC_ADDR_CONTROL_HIGH, q);
            `CHK(q & 16'hFFEF, {s[0], 15'h0000})
            `CHK(halt, s[0])
            rd(0, HIC_ADDR_MAILBOX_LOW, q);
            `CHK(q, mbox_m[0])
        end
        complete_run;
    end
endmodule
